//--- rtl/tpg_pkg.sv
// constants, types and helpers for the csi-2 test pattern generator
// assumes one 10 mhz clock; used by every design file of the block
package tpg_pkg;

////////////////////////////////////////////////////////////////////////
// directly addressed byte registers
localparam logic [7:0] A_PAGE = 8'hB0; // page select
localparam logic [7:0] A_IDX = 8'hB1; // indirect offset
localparam logic [7:0] A_DATA = 8'hB2; // indirect data
localparam logic [7:0] PAGE_GEN = 8'h00; // generator page

// indirect offsets on the generator page
localparam int N_REGS = 32;
localparam logic [7:0] I_CTL = 8'h01;
localparam logic [7:0] I_CFG = 8'h02;
localparam logic [7:0] I_PID = 8'h03;
localparam logic [7:0] I_LSZ_H = 8'h04;
localparam logic [7:0] I_LSZ_L = 8'h05;
localparam logic [7:0] I_BAR_H = 8'h06;
localparam logic [7:0] I_BAR_L = 8'h07;
localparam logic [7:0] I_ACT_H = 8'h08;
localparam logic [7:0] I_ACT_L = 8'h09;
localparam logic [7:0] I_TOT_H = 8'h0A;
localparam logic [7:0] I_TOT_L = 8'h0B;
localparam logic [7:0] I_LPD_H = 8'h0C;
localparam logic [7:0] I_LPD_L = 8'h0D;
localparam logic [7:0] I_VBP = 8'h0E;
localparam logic [7:0] I_VFP = 8'h0F;
localparam logic [7:0] I_PAT0 = 8'h10; // 16 fixed pattern bytes
localparam logic [7:0] I_STAT = 8'h20; // read-only status

// field positions and reset values
localparam int CTL_EN = 0;
localparam int CFG_FIXED = 7;
localparam int CFG_BARS_LSB = 4;
localparam int CFG_BLK_LSB = 0;
localparam logic [7:0] REG_RST = 8'h00;
localparam logic [7:0] CFG_RST = 8'h33;

// packet constants
localparam logic [5:0] DT_FS = 6'h00;
localparam logic [5:0] DT_FE = 6'h01;
localparam logic [15:0] CRC_SEED = 16'hFFFF;
localparam logic [15:0] CRC_POLY = 16'h8408;
localparam logic [5:0][23:0] ECC_MASK = {24'hEFFC00, 24'hDF03F0, 24'hB8E38E,
   24'h749A6D, 24'hF2555B, 24'hF12CB7};
localparam logic [7:0][7:0] BAR_COLOR = {8'h80, 8'h0F, 8'hCC, 8'h55,
   8'h7F, 8'hF0, 8'h33, 8'hAA};

// line period unit timing
localparam int CLK_NS = 100;
localparam int UNIT_NS = 10;
localparam int UNIT_SLOW_NS = 20;
localparam int UNIT_CYC = (UNIT_NS / CLK_NS < 1) ? 1 : UNIT_NS / CLK_NS;
localparam int UNIT_SLOW_CYC = (UNIT_SLOW_NS / CLK_NS < 1) ? 1 : UNIT_SLOW_NS / CLK_NS;

typedef enum logic [1:0] {S_IDLE, S_HDR, S_PAY, S_CRC} tpg_state_t;

// packet header error code over the three header bytes
function automatic logic [7:0] tpg_ecc(input logic [23:0] h);
   logic [7:0] e;
   e = 8'h00;
   for (int i = 0; i < 6; i++)
      e[i] = ^(h & ECC_MASK[i]);
   return e;
endfunction

// payload checksum, one byte, lsb first
function automatic logic [15:0] tpg_crc(input logic [15:0] c, input logic [7:0] b);
   logic [15:0] r;
   logic fb;
   r = c;
   for (int i = 0; i < 8; i++)
   begin
      fb = r[0] ^ b[i];
      r = r >> 1;
      if (fb)
         r = r ^ CRC_POLY;
   end
   return r;
endfunction

endpackage

//--- rtl/tpg_buf.sv
// two-entry buffer between packet sequencer and transmitter
// assumes active-low reset from the top, asserted asynchronously and released on the clock
`timescale 1ns/1ps
module tpg_buf
   import tpg_pkg::*;
#(
   parameter int W = 9
)(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   // entries and their valid flags
   typedef struct packed {
      logic [1:0][W-1:0] ent;
      logic [1:0] vld;
   } tpg_buf_t;
   tpg_buf_t buf_q, buf_d;

   ////////////////////////////////////////////////////////////////////
   // pop from head, then push into first free slot
   always_comb
   begin
      buf_d = buf_q;
      if (out_ready && buf_q.vld[0])
      begin
         buf_d.ent[0] = buf_q.ent[1];
         buf_d.vld = {1'b0, buf_q.vld[1]};
      end
      if (in_valid && !buf_q.vld[1])
      begin
         if (!buf_d.vld[0])
         begin
            buf_d.ent[0] = in_data;
            buf_d.vld[0] = 1'b1;
         end
         else
         begin
            buf_d.ent[1] = in_data;
            buf_d.vld[1] = 1'b1;
         end
      end
   end

   // state register
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         buf_q <= '0;
      else
         buf_q <= buf_d;
   end

   assign in_ready = !buf_q.vld[1];
   assign out_valid = buf_q.vld[0];
   assign out_data = buf_q.ent[0];

   ////////////////////////////////////////////////////////////////////
   a_buf_stall_hold: assert property (@(posedge clock) disable iff (!rst_n)
      out_valid && !out_ready |=> out_valid && $stable(out_data))
      else $error("buffer head changed while stalled");
   a_buf_full_block: assert property (@(posedge clock) disable iff (!rst_n)
      buf_q.vld[1] && !out_ready |=> !in_ready)
      else $error("buffer accepted while full");
   c_buf_full: cover property (@(posedge clock) disable iff (!rst_n) buf_q.vld[1]);
endmodule // tpg_buf

//--- rtl/tpg_regs.sv
// page, offset and data registers with the indirect generator page
// assumes byte writes on a simple strobe, reads one cycle after address
`timescale 1ns/1ps
module tpg_regs
   import tpg_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic wr,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] status,
   output logic [7:0] rdata,
   output logic [N_REGS-1:0][7:0] regs
);
   // page, offset, indirect array and read data
   typedef struct packed {
      logic [7:0] page;
      logic [7:0] idx;
      logic [N_REGS-1:0][7:0] mem;
      logic [7:0] rdata;
   } tpg_regs_t;
   tpg_regs_t r_q, r_d;
   logic gen_page;
   logic ind_hit;

   assign gen_page = (r_q.page == PAGE_GEN);
   assign ind_hit = gen_page && (r_q.idx < 8'(N_REGS));

   ////////////////////////////////////////////////////////////////////
   // write decode and registered read mux
   always_comb
   begin
      r_d = r_q;
      if (wr)
      begin
         case (addr)
            A_PAGE: r_d.page = wdata;
            A_IDX: r_d.idx = wdata;
            A_DATA:
               if (ind_hit && r_q.idx != 8'h00)
                  r_d.mem[r_q.idx[4:0]] = wdata;
            default: ;
         endcase
      end
      // unmapped addresses read as zero
      case (addr)
         A_PAGE: r_d.rdata = r_q.page;
         A_IDX: r_d.rdata = r_q.idx;
         A_DATA:
            if (ind_hit)
               r_d.rdata = r_q.mem[r_q.idx[4:0]];
            else if (gen_page && r_q.idx == I_STAT)
               r_d.rdata = status;
            else
               r_d.rdata = 8'h00;
         default: r_d.rdata = 8'h00;
      endcase
   end

   // state register, configuration defaults to eight bars
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         r_q <= '0;
         r_q.mem[I_CFG[4:0]] <= CFG_RST;
      end
      else
         r_q <= r_d;
   end

   assign rdata = r_q.rdata;
   assign regs = r_q.mem;

   ////////////////////////////////////////////////////////////////////
   a_ind_write: assert property (@(posedge clock) disable iff (!rst_n)
      wr && addr == A_DATA && ind_hit && r_q.idx != 8'h00
      |=> regs[$past(r_q.idx[4:0])] == $past(wdata))
      else $error("indirect write not stored");
endmodule // tpg_regs

//--- rtl/tpg_top.sv
// csi-2 test pattern generator: settings, frame timing, packet sequencer
// assumes the transmitter takes one formatted byte per accepted beat
//
// How it works
// - color bar or fixed color pattern kinds
// - eight bars AA 33 F0 7F 55 CC 0F 80
// - last bar stretches to fill line
// - one, two, four or eight bars
// - programmable line, bar, type, channel
// - active lines within total lines per frame
// - porch blank lines around active lines
// - line period unit 10 ns, 20 ns slow, both held to one 100 ns clock
// - formatted packets to transmitter through a two-entry buffer
// - fixed mode repeats programmed byte block
// - fixed mode alternates pattern and inverse
// - block up to sixteen programmed bytes
// - settings through page, offset, data
`timescale 1ns/1ps
module tpg_top
   import tpg_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic speed_400m,
   input wire logic reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic tx_ready,
   output logic tx_valid,
   output logic [7:0] tx_data,
   output logic tx_last
);
   ////////////////////////////////////////////////////////////////////
   // reset release through two flops
   logic [1:0] rs_q;
   logic rst_n_s;

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         rs_q <= 2'b00;
      else
         rs_q <= {rs_q[0], 1'b1};
   end
   assign rst_n_s = rs_q[1];

   ////////////////////////////////////////////////////////////////////
   // register file
   logic [N_REGS-1:0][7:0] regs; // indirect settings
   logic [7:0] status; // running and active-line flags

   tpg_regs u_regs (
      .clock(clock),
      .rst_n(rst_n_s),
      .wr(reg_wr),
      .addr(reg_addr),
      .wdata(reg_wdata),
      .status(status),
      .rdata(reg_rdata),
      .regs(regs)
   );

   // decoded settings
   logic en; // generator enable
   logic fixed; // fixed color mode
   logic [1:0] bsel; // bar count code
   logic [3:0] blk_max; // fixed block size minus one
   logic [7:0] pid; // channel and data type
   logic [15:0] lsz; // payload bytes per line
   logic [15:0] barsz; // bytes per bar
   logic [15:0] act_n; // active lines
   logic [15:0] tot_n; // total lines
   logic [15:0] lpd; // line period in units
   logic [7:0] vbp; // back porch lines
   logic [7:0] vfp; // front porch lines

   assign en = regs[I_CTL[4:0]][CTL_EN];
   assign fixed = regs[I_CFG[4:0]][CFG_FIXED];
   assign bsel = regs[I_CFG[4:0]][CFG_BARS_LSB +: 2];
   assign blk_max = regs[I_CFG[4:0]][CFG_BLK_LSB +: 4];
   assign pid = regs[I_PID[4:0]];
   assign lsz = {regs[I_LSZ_H[4:0]], regs[I_LSZ_L[4:0]]};
   assign barsz = {regs[I_BAR_H[4:0]], regs[I_BAR_L[4:0]]};
   assign act_n = {regs[I_ACT_H[4:0]], regs[I_ACT_L[4:0]]};
   assign tot_n = {regs[I_TOT_H[4:0]], regs[I_TOT_L[4:0]]};
   assign lpd = {regs[I_LPD_H[4:0]], regs[I_LPD_L[4:0]]};
   assign vbp = regs[I_VBP[4:0]];
   assign vfp = regs[I_VFP[4:0]];

   ////////////////////////////////////////////////////////////////////
   // sequencer state
   typedef struct packed {
      tpg_state_t st;
      logic [3:0] unit; // unit divider
      logic [15:0] lp; // units within line
      logic [15:0] line; // line within frame
      logic [1:0] bi; // header or checksum byte
      logic [31:0] hdr; // packet header with ecc
      logic lng; // long packet
      logic [15:0] pc; // payload bytes sent
      logic [15:0] bb; // byte within bar
      logic [2:0] bar; // bar index
      logic [3:0] blk; // byte within block
      logic [15:0] crc; // running checksum
      logic act; // in active line
   } tpg_core_t;
   tpg_core_t c_q, c_d;

   // buffer side, line timing and pattern signals
   logic buf_ready; // buffer can take a byte
   logic push; // byte accepted this cycle
   logic [7:0] byte_o; // byte offered
   logic last_o; // last byte of packet
   logic [2:0] nbm1; // bars minus one
   logic [3:0] umax; // divider terminal count
   logic tick; // one line period unit
   logic lp_end; // last unit of line
   logic line_start; // new line begins
   logic [15:0] first_act; // first active line
   logic [15:0] last_act; // last active line
   logic [15:0] fe_line; // line carrying frame end
   logic [7:0] pix; // pattern byte

   assign nbm1 = 3'((4'd1 << bsel) - 4'd1);
   assign first_act = 16'(vbp) + 16'd1;
   assign last_act = 16'(vbp) + act_n;
   assign fe_line = last_act + 16'(vfp) + 16'd1;
   assign umax = speed_400m ? 4'(UNIT_SLOW_CYC - 1) : 4'(UNIT_CYC - 1);
   assign tick = (c_q.unit == umax);
   assign lp_end = (lpd == 16'd0) || (c_q.lp >= lpd - 16'd1);
   assign line_start = en && tick && lp_end;
   assign push = (c_q.st != S_IDLE) && buf_ready;
   assign status = {6'h00, c_q.act, c_q.st != S_IDLE};

   // pattern byte: fixed block with inverse on odd bars, or bar color
   assign pix = fixed ? (regs[5'(I_PAT0) + 5'(c_q.blk)] ^ {8{c_q.bar[0]}})
      : BAR_COLOR[c_q.bar];

   ////////////////////////////////////////////////////////////////////
   // byte mux for the current packet field
   always_comb
   begin
      byte_o = 8'h00;
      last_o = 1'b0;
      case (c_q.st)
         S_HDR:
         begin
            byte_o = c_q.hdr[8*c_q.bi +: 8];
            last_o = !c_q.lng && c_q.bi == 2'd3;
         end
         S_PAY: byte_o = pix;
         S_CRC:
         begin
            byte_o = c_q.bi[0] ? c_q.crc[15:8] : c_q.crc[7:0];
            last_o = c_q.bi[0];
         end
         default: ;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // line timing and packet sequencing
   always_comb
   begin
      logic [15:0] wc;
      logic [5:0] dt;
      logic go;
      logic lg;
      wc = 16'h0000;
      dt = DT_FS;
      go = 1'b0;
      lg = 1'b0;
      c_d = c_q;
      // unit divider and line period count
      c_d.unit = tick ? 4'h0 : c_q.unit + 4'h1;
      if (tick)
         c_d.lp = lp_end ? 16'h0000 : c_q.lp + 16'h0001;
      if (line_start)
         c_d.line = (c_q.line >= tot_n - 16'd1) ? 16'h0000 : c_q.line + 16'h0001;
      if (!en)
      begin
         c_d.unit = 4'h0;
         c_d.lp = 16'h0000;
         c_d.line = 16'h0000;
      end
      c_d.act = en && c_q.line >= first_act && c_q.line <= last_act;
      // pick the packet for a new line
      if (line_start && c_q.st == S_IDLE)
      begin
         if (c_q.line == 16'd0)
            go = 1'b1;
         else if (act_n != 16'd0 && c_q.line >= first_act && c_q.line <= last_act)
         begin
            go = 1'b1;
            lg = 1'b1;
            dt = pid[5:0];
            wc = lsz;
         end
         else if (c_q.line == fe_line && fe_line < tot_n)
         begin
            go = 1'b1;
            dt = DT_FE;
         end
      end
      if (go)
      begin
         c_d.st = S_HDR;
         c_d.lng = lg;
         c_d.hdr = {tpg_ecc({wc, pid[7:6], dt}), wc, pid[7:6], dt};
         c_d.bi = 2'd0;
         c_d.pc = 16'h0000;
         c_d.bb = 16'h0000;
         c_d.bar = 3'd0;
         c_d.blk = 4'h0;
         c_d.crc = CRC_SEED;
      end
      // advance on each accepted byte
      if (push)
      begin
         case (c_q.st)
            S_HDR:
            begin
               c_d.bi = c_q.bi + 2'd1;
               if (c_q.bi == 2'd3)
               begin
                  c_d.bi = 2'd0;
                  if (!c_q.lng)
                     c_d.st = S_IDLE;
                  else if (lsz == 16'd0)
                     c_d.st = S_CRC;
                  else
                     c_d.st = S_PAY;
               end
            end
            S_PAY:
            begin
               c_d.crc = tpg_crc(c_q.crc, pix);
               c_d.pc = c_q.pc + 16'h0001;
               c_d.blk = (c_q.blk >= blk_max) ? 4'h0 : c_q.blk + 4'h1;
               c_d.bb = c_q.bb + 16'h0001;
               // every bar but the last ends at the bar size
               if (c_q.bar != nbm1 && c_q.bb == barsz - 16'd1)
               begin
                  c_d.bar = c_q.bar + 3'd1;
                  c_d.bb = 16'h0000;
                  c_d.blk = 4'h0;
               end
               if (c_q.pc == lsz - 16'd1)
                  c_d.st = S_CRC;
            end
            S_CRC:
            begin
               c_d.bi = c_q.bi + 2'd1;
               if (c_q.bi[0])
                  c_d.st = S_IDLE;
            end
            default: c_d.st = S_IDLE;
         endcase
      end
   end

   // state register
   always_ff @(posedge clock or negedge rst_n_s)
   begin
      if (!rst_n_s)
         c_q <= '0;
      else
         c_q <= c_d;
   end

   ////////////////////////////////////////////////////////////////////
   // two-entry buffer toward the transmitter
   tpg_buf #(
      .W(9)
   ) u_buf (
      .clock(clock),
      .rst_n(rst_n_s),
      .in_valid(c_q.st != S_IDLE),
      .in_ready(buf_ready),
      .in_data({last_o, byte_o}),
      .out_valid(tx_valid),
      .out_ready(tx_ready),
      .out_data({tx_last, tx_data})
   );

   ////////////////////////////////////////////////////////////////////
   // checks on the sequencer
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n_s);

   a_frame_start: assert property (line_start && c_q.st == S_IDLE && c_q.line == 16'd0
      |=> c_q.st == S_HDR && c_q.hdr[5:0] == DT_FS && !c_q.lng)
      else $error("frame start not issued on line zero");
   a_stop_disabled: assert property (!en && c_q.st == S_IDLE |=> c_q.st == S_IDLE)
      else $error("packet started while disabled");
   a_line_wrap: assert property (line_start && tot_n != 16'd0 && c_q.line == tot_n - 16'd1
      |=> c_q.line == 16'd0)
      else $error("frame did not wrap at total lines");
   a_bar_limit: assert property (c_q.st == S_PAY |-> c_q.bar <= nbm1)
      else $error("bar index beyond bar count");
   a_last_bar: assert property (c_q.st == S_PAY && c_q.bar == nbm1
      |=> c_q.st != S_PAY || c_q.bar == nbm1)
      else $error("last bar did not stretch");
   // every bar but the last stays inside the programmed bar size
   a_bar_color: assert property (push && c_q.st == S_PAY && !fixed
      |-> byte_o == BAR_COLOR[c_q.bar] && (c_q.bar == nbm1 || barsz == 16'd0 || c_q.bb < barsz))
      else $error("wrong bar color");
   a_fixed_inverse: assert property (push && c_q.st == S_PAY && fixed && c_q.bar[0]
      |-> byte_o == ~regs[5'(I_PAT0) + 5'(c_q.blk)] && c_q.blk <= blk_max)
      else $error("odd bar not inverted");
   a_payload_len: assert property (push && c_q.st == S_PAY && c_q.pc == lsz - 16'd1
      |=> c_q.st == S_CRC ##1 c_q.st == S_CRC || $past(push) == 1'b0)
      else $error("payload length wrong");
   a_header_id: assert property (push && c_q.st == S_HDR && c_q.bi == 2'd0 && c_q.lng
      |-> byte_o == pid)
      else $error("packet id byte wrong");
   a_header_len: assert property (push && c_q.st == S_HDR && c_q.bi == 2'd3
      |=> c_q.st != S_HDR)
      else $error("header longer than four bytes");

   c_fs_sent: cover property (push && c_q.st == S_HDR && c_q.hdr[5:0] == DT_FS && last_o);
   c_fe_sent: cover property (push && c_q.st == S_HDR && c_q.hdr[5:0] == DT_FE && last_o);
   c_long_done: cover property (push && c_q.st == S_CRC && c_q.bi[0]);
   c_fixed_line: cover property (push && c_q.st == S_PAY && fixed && c_q.bar == 3'd1);
endmodule // tpg_top

//--- sim/tpg_sink.sv
// transmitter model: takes packet bytes, stalls at random when asked
// assumes one byte per beat, taken on the rising edge
`timescale 1ns/1ps
module tpg_sink
(
   input wire logic clock,
   input wire logic stall_en,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic tx_last,
   output logic tx_ready
);
   logic [7:0] bq[$]; // accepted bytes
   logic lq[$]; // packet end marks
   int seed = 32'h239f; // fixed stall seed
   initial tx_ready = 1'b0;
   ////////////////////////////////////////////////////////////////////////
   // take a byte on each accepting edge, then pick the next ready level
   always @(posedge clock)
   begin
      if (tx_valid === 1'b1 && tx_ready)
      begin
         bq.push_back(tx_data);
         lq.push_back(tx_last);
      end
      #1 tx_ready = !(stall_en && ($random(seed) & 3) == 0);
   end
endmodule // tpg_sink

//--- sim/tb_tpg_top.sv
// bench for the pattern generator: registers, frames in both pattern kinds
// assumes tpg_sink as transmitter, one 10 mhz clock
`timescale 1ns/1ps
module tb_tpg_top
   import tpg_pkg::*;
;
   logic clock, rstn, speed_400m, reg_wr, tx_ready, tx_valid, tx_last, stall_en;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, tx_data;
   int errors, checks_done;
   int seed = 32'h239f;
   logic [7:0] pat[16]; // fixed pattern bytes
   ////////////////////////////////////////////////////////////////////////
   // design and transmitter model
   tpg_top i_tpg_top (.clock(clock), .rstn(rstn), .speed_400m(speed_400m), .reg_wr(reg_wr),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .tx_ready(tx_ready),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last));
   tpg_sink i_tpg_sink (.clock(clock), .stall_en(stall_en), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready));
   always #50 clock = ~clock;
   ////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e)
      begin
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
         errors++;
      end
   endtask
   // register bus cycles, held back to back
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge clock);
      #1;
   endtask
   task automatic iwr(input logic [7:0] o, input logic [7:0] d);
      wr(A_IDX, o);
      wr(A_DATA, d);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      reg_wr = 1'b0;
      reg_addr = a;
      repeat (2) @(posedge clock);
      #1 d = reg_rdata;
   endtask
   task automatic ird(input logic [7:0] o, output logic [7:0] d);
      wr(A_IDX, o);
      rd(A_DATA, d);
   endtask
   // next accepted byte, bounded wait
   task automatic pop(output logic [7:0] d, output logic l);
      int n;
      n = 0;
      while (i_tpg_sink.bq.size() == 0 && n < 3000)
      begin
         @(posedge clock);
         #1;
         n++;
      end
      if (i_tpg_sink.bq.size() == 0)
      begin
         $display("[FAIL] stream expected byte seen none");
         errors++;
         summarize();
      end
      else
      begin
         d = i_tpg_sink.bq.pop_front();
         l = i_tpg_sink.lq.pop_front();
      end
   endtask
   // payload byte at position i of an active line
   function automatic logic [7:0] exp_byte(input logic [7:0] cfg, input int bar, input int i);
      int n;
      int b;
      int k;
      n = 1 << cfg[5:4];
      b = i / bar;
      if (b > n - 1)
         b = n - 1;
      k = (i - b * bar) % (cfg[3:0] + 1);
      if (!cfg[CFG_FIXED])
         return BAR_COLOR[b];
      return b[0] ? ~pat[k] : pat[k];
   endfunction
   // payload checksum step over one byte, lsb first
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
      for (int j = 0; j < 8; j++)
         c = (c >> 1) ^ ((c[0] ^ b[j]) ? CRC_POLY : 16'h0000);
      return c;
   endfunction
   task automatic short_pkt(input logic [7:0] di);
      logic [7:0] d;
      logic l;
      pop(d, l);
      chk("short id", di, d);
      repeat (3) pop(d, l);
      chk("short end", 8'h01, {7'h00, l});
   endtask
   task automatic frame(input logic [7:0] pid, input logic [7:0] cfg, input int nb, input int bar,
      input int act);
      logic [7:0] d;
      logic l;
      logic [15:0] crc;
      short_pkt({pid[7:6], DT_FS});
      for (int r = 0; r < act; r++)
      begin
         pop(d, l);
         chk("long id", pid, d);
         pop(d, l);
         chk("count lo", nb[7:0], d);
         pop(d, l);
         chk("count hi", nb[15:8], d);
         pop(d, l);
         crc = CRC_SEED;
         for (int i = 0; i < nb; i++)
         begin
            pop(d, l);
            chk("payload", exp_byte(cfg, bar, i), d);
            crc = crc_step(crc, d);
         end
         pop(d, l);
         chk("crc low", crc[7:0], d);
         pop(d, l);
         chk("crc high", crc[15:8], d);
         chk("long end", 8'h01, {7'h00, l});
      end
      short_pkt({pid[7:6], DT_FE});
   endtask
   ////////////////////////////////////////////////////////////////////////
   // watchdog
   initial
   begin
      repeat (60000) @(posedge clock);
      errors++;
      summarize();
   end
   // main sequence
   initial
   begin
      logic [7:0] d, cfg, pid;
      logic [7:0] vals[12];
      int nb, bar, act, blk, lpd;
      clock = 0;
      rstn = 0;
      speed_400m = 0;
      reg_wr = 0;
      reg_addr = 0;
      reg_wdata = 0;
      stall_en = 0;
      errors = 0;
      checks_done = 0;
      repeat (4) @(posedge clock);
      #1 rstn = 1;
      repeat (3) @(posedge clock);
      #1;
      ird(I_CFG, d);
      chk("config reset", CFG_RST, d);
      ird(I_CTL, d);
      chk("control reset", REG_RST, d);
      wr(A_PAGE, 8'h01);
      iwr(I_PID, 8'h5A);
      wr(A_PAGE, PAGE_GEN);
      ird(I_PID, d);
      chk("other page", REG_RST, d);
      iwr(I_STAT, 8'hFF);
      ird(I_STAT, d);
      chk("status", 8'h00, d);
      rd(8'h40, d);
      chk("unmapped", 8'h00, d);
      $display("test registers done");
      stall_en = 1;
      for (int t = 0; t < 5; t++)
      begin
         // four bar counts in color mode, then fixed mode with two bars
         cfg = {2'b00, t[1:0], 4'h0};
         if (t == 4)
            cfg = {2'b10, 2'b01, 4'($random(seed))};
         for (int j = 0; j < 16; j++)
         begin
            pat[j] = 8'($random(seed));
            iwr(I_PAT0 + 8'(j), pat[j]);
         end
         pid = 8'($random(seed)) | 8'h20;
         // one byte per pixel in color mode, one block per pixel in fixed mode
         blk = cfg[CFG_FIXED] ? int'(cfg[3:0]) + 1 : 1;
         nb = blk * (cfg[CFG_FIXED] ? 2 + 2 * ($random(seed) & 1) : 8 + ($random(seed) & 15));
         // whole blocks per bar, rounded down, so bars stay block aligned
         bar = nb / blk / (1 << cfg[5:4]) * blk;
         act = 1 + ($random(seed) & 1);
         // frame of 1600 units spread over eight total lines
         lpd = 1600 / 8;
         speed_400m = t[0];
         vals = '{8'h00, 8'(nb), 8'h00, 8'(bar), 8'h00, 8'(act), 8'h00, 8'h08, 8'h00, 8'(lpd),
            8'h01, 8'h01};
         for (int j = 0; j < 12; j++)
            iwr(I_LSZ_H + 8'(j), vals[j]);
         iwr(I_CFG, cfg);
         iwr(I_PID, pid);
         ird(I_PID, d);
         chk("packet id", pid, d);
         // write to unmapped address 20 before the generator starts
         wr(8'h20, 8'h30);
         iwr(I_CTL, 8'h01);
         reg_wr = 1'b0;
         frame(pid, cfg, nb, bar, act);
         iwr(I_CTL, 8'h00);
         reg_wr = 1'b0;
         repeat (200) @(posedge clock);
         i_tpg_sink.bq.delete();
         i_tpg_sink.lq.delete();
         repeat (800) @(posedge clock);
         #1;
         chk("stopped", 8'h00, 8'(i_tpg_sink.bq.size()));
         $display("test frame %0d done", t);
      end
      summarize();
   end
endmodule // tb_tpg_top
